// [hdl/dwss_line_sync.v]
// Purpose: Synchronise serial clock and data, find edges and bus conditions
// Assumes: Pins are asynchronous to core_clk, serial clock far slower
// Notes: Stage one of each synchroniser feeds only stage two
`timescale 1ns/1ps

module dwss_line_sync (
  input wire core_clk,
  input wire rst,
  input wire sclPin,
  input wire sdaPin,
  output wire sdaLevel,
  output wire sclRise,
  output wire sclFall,
  output wire startSeen,
  output wire stopSeen
);

  reg [1:0] sclMeta;
  reg [1:0] sdaMeta;
  reg sclLast;
  reg sdaLast;

  // ----------------------------------------
  // Two-stage synchronisers plus history
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      sclMeta <= 2'h3;
      sdaMeta <= 2'h3;
      sclLast <= 1'b1;
      sdaLast <= 1'b1;
    end else begin
      sclMeta <= {sclMeta[0], sclPin};
      sdaMeta <= {sdaMeta[0], sdaPin};
      sclLast <= sclMeta[1];
      sdaLast <= sdaMeta[1];
    end
  end

  assign sdaLevel = sdaMeta[1];
  assign sclRise = sclMeta[1] & ~sclLast;
  assign sclFall = ~sclMeta[1] & sclLast;
  assign startSeen = sclMeta[1] & sclLast & sdaLast & ~sdaMeta[1];
  assign stopSeen = sclMeta[1] & sclLast & ~sdaLast & sdaMeta[1];

endmodule // dwss_line_sync

// [hdl/dwss_map.vh]
// Purpose: Constants for the dual wiper setting store
// Assumes: Included by the setting store design file and the bench; the line synchroniser does not use it
// Notes: Definitions only
//
// How it works
// - Each channel has its own 8-bit wiper register that alone picks the tap.
// - All 256 wiper codes map one-to-one onto 256 tap selects.
// - Four 8-bit stored setting registers belong to each wiper register.
// - After reset each wiper loads its channel's first stored setting unprompted.
// - Apart from reset and its recall, wiper and stored settings change only through host writes on the serial port.
// - Every transfer is timed by the host's serial clock; the device only samples it.
// - Data line is only pulled low or released, never driven high.
// - Four address straps form part of the slave address, sixteen devices per bus.
// - Only an address matching the straps is acknowledged; others are ignored.
// - Write guard low refuses stored setting writes but allows wiper writes.
// - Write guard high or floating allows all reads and writes.
`ifndef DWSS_MAP_VH
`define DWSS_MAP_VH

// ----------------------------------------
// Slave address byte: {family, straps}
// ----------------------------------------
`define DWSS_FAMILY_ID 4'h5
`define DWSS_ADDR_FAM_HI 7
`define DWSS_ADDR_FAM_LO 4

// ----------------------------------------
// Command byte fields
// ----------------------------------------
`define DWSS_CMD_READ 7
`define DWSS_CMD_STORE 6
`define DWSS_CMD_CHAN 4
`define DWSS_CMD_IDX_HI 1
`define DWSS_CMD_IDX_LO 0

// ----------------------------------------
// Register layout and values
// ----------------------------------------
`define DWSS_CHANNELS 2
`define DWSS_SETTINGS 4
`define DWSS_DATA_W 8
`define DWSS_TAPS 256
`define DWSS_STORE_INIT 8'h80
`define DWSS_WIPER_RST 8'h00

`endif

// [hdl/dwss_setting_store.v]
// Purpose: Dual wiper registers with stored settings behind a 2-wire slave
// Assumes: Host frames: START, address byte, command byte, then one data byte
// Notes: Stored array survives rst, standing in for nonvolatile cells
`timescale 1ns/1ps
`include "dwss_map.vh"

module dwss_setting_store #(
  parameter [3:0] FAMILY_ID = `DWSS_FAMILY_ID,
  parameter [7:0] STORE_INIT = `DWSS_STORE_INIT
) (
  input wire core_clk,
  input wire rst,
  input wire sclPin,
  input wire sdaPin,
  output wire sdaOut,
  output reg sdaOeN,
  input wire [3:0] busSelectStrap,
  input wire writeGuardN,
  output reg [7:0] wiperPosition0,
  output reg [7:0] wiperPosition1,
  output reg [255:0] tapSelect0,
  output reg [255:0] tapSelect1,
  output reg recallBusy
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_CMD = 4'h2;
  localparam [3:0] ST_WDATA = 4'h3;
  localparam [3:0] ST_ACK = 4'h4;
  localparam [3:0] ST_RDATA = 4'h5;
  localparam [3:0] ST_RACK = 4'h6;
  localparam [3:0] ST_WAIT = 4'h7;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [7:0] storedSetting [0:7];
  integer i;
  initial begin
    for (i = 0; i < 8; i = i + 1) begin
      storedSetting[i] = STORE_INIT;
    end
  end

  function [255:0] tapDecode;
    input [7:0] code;
    begin
      tapDecode = {{255{1'b0}}, 1'b1} << code;
    end
  endfunction

  function [2:0] storeIndex;
    input chan;
    input [1:0] idx;
    begin
      storeIndex = {chan, idx};
    end
  endfunction

  // ----------------------------------------
  // Pin sampling
  // ----------------------------------------
  wire sdaLevel;
  wire sclRise;
  wire sclFall;
  wire startSeen;
  wire stopSeen;
  reg [3:0] strapMeta;
  reg [3:0] strapSync;
  reg [1:0] guardMeta;

  dwss_line_sync lineSync (
    .core_clk(core_clk),
    .rst(rst),
    .sclPin(sclPin),
    .sdaPin(sdaPin),
    .sdaLevel(sdaLevel),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .startSeen(startSeen),
    .stopSeen(stopSeen)
  );

  always @(posedge core_clk) begin
    if (rst) begin
      strapMeta <= 4'h0;
      strapSync <= 4'h0;
      guardMeta <= 2'h3;
    end else begin
      strapMeta <= busSelectStrap;
      strapSync <= strapMeta;
      guardMeta <= {guardMeta[0], writeGuardN};
    end
  end

  wire guardOpen = guardMeta[1];

  // ----------------------------------------
  // Serial protocol engine
  // ----------------------------------------
  reg [3:0] state;
  reg [3:0] ackNext;
  reg [2:0] bitCnt;
  reg [7:0] shiftIn;
  reg [7:0] txByte;
  reg ackGive;
  reg ackHeld;
  reg cmdRead;
  reg cmdStore;
  reg cmdChan;
  reg [1:0] cmdIdx;
  reg storeWrite;
  reg [2:0] storeAddr;
  reg [7:0] storeData;

  wire [7:0] byteIn = {shiftIn[6:0], sdaLevel};
  wire byteDone = sclRise && (bitCnt == 3'h7);
  wire [7:0] wiperSel = byteIn[`DWSS_CMD_CHAN] ? wiperPosition1 : wiperPosition0;
  wire [7:0] storeSel = storedSetting[storeIndex(byteIn[`DWSS_CMD_CHAN],
                                                 byteIn[`DWSS_CMD_IDX_HI:`DWSS_CMD_IDX_LO])];

  assign sdaOut = 1'b0;

  always @(posedge core_clk) begin
    storeWrite <= 1'b0;
    if (rst) begin
      state <= ST_IDLE;
      ackNext <= ST_IDLE;
      bitCnt <= 3'h0;
      shiftIn <= 8'h00;
      txByte <= 8'h00;
      ackGive <= 1'b0;
      ackHeld <= 1'b0;
      cmdRead <= 1'b0;
      cmdStore <= 1'b0;
      cmdChan <= 1'b0;
      cmdIdx <= 2'h0;
      sdaOeN <= 1'b1;
      storeAddr <= 3'h0;
      storeData <= 8'h00;
      wiperPosition0 <= `DWSS_WIPER_RST;
      wiperPosition1 <= `DWSS_WIPER_RST;
      recallBusy <= 1'b1;
    end else if (recallBusy) begin
      // Wait out recall so a frame cannot race the load
      wiperPosition0 <= storedSetting[storeIndex(1'b0, 2'h0)];
      wiperPosition1 <= storedSetting[storeIndex(1'b1, 2'h0)];
      recallBusy <= 1'b0;
    end else if (startSeen) begin
      state <= ST_ADDR;
      bitCnt <= 3'h0;
      ackHeld <= 1'b0;
      sdaOeN <= 1'b1;
    end else if (stopSeen) begin
      state <= ST_IDLE;
      sdaOeN <= 1'b1;
    end else begin
      case (state)
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (sclRise) begin
            shiftIn <= byteIn;
            bitCnt <= bitCnt + 3'h1;
          end
          if (byteDone) begin
            state <= ST_ACK;
            ackHeld <= 1'b0;
            ackGive <= 1'b1;
            if (state == ST_ADDR) begin
              if (byteIn[`DWSS_ADDR_FAM_HI:`DWSS_ADDR_FAM_LO] == FAMILY_ID &&
                  byteIn[3:0] == strapSync) begin
                ackNext <= ST_CMD;
              end else begin
                state <= ST_WAIT;
              end
            end else if (state == ST_CMD) begin
              cmdRead <= byteIn[`DWSS_CMD_READ];
              cmdStore <= byteIn[`DWSS_CMD_STORE];
              cmdChan <= byteIn[`DWSS_CMD_CHAN];
              cmdIdx <= byteIn[`DWSS_CMD_IDX_HI:`DWSS_CMD_IDX_LO];
              txByte <= byteIn[`DWSS_CMD_STORE] ? storeSel : wiperSel;
              ackNext <= byteIn[`DWSS_CMD_READ] ? ST_RDATA : ST_WDATA;
            end else begin
              ackNext <= ST_WAIT;
              if (cmdStore) begin
                if (guardOpen) begin
                  storeWrite <= 1'b1;
                  storeAddr <= storeIndex(cmdChan, cmdIdx);
                  storeData <= byteIn;
                end else begin
                  ackGive <= 1'b0;
                end
              end else if (cmdChan) begin
                wiperPosition1 <= byteIn;
              end else begin
                wiperPosition0 <= byteIn;
              end
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            if (!ackHeld) begin
              ackHeld <= 1'b1;
              sdaOeN <= ~ackGive;
            end else begin
              ackHeld <= 1'b0;
              bitCnt <= 3'h0;
              state <= ackNext;
              // Read data goes out on the same falling edge that ends the ack
              sdaOeN <= (ackNext == ST_RDATA) ? txByte[7] : 1'b1;
            end
          end
        end
        ST_RDATA: begin
          if (sclRise) begin
            bitCnt <= bitCnt + 3'h1;
            if (bitCnt == 3'h7) begin
              state <= ST_RACK;
            end
          end
          if (sclFall) begin
            sdaOeN <= txByte[3'h7 - bitCnt];
          end
        end
        ST_RACK: begin
          // Release for the host's ack; one byte per frame
          if (sclFall) begin
            sdaOeN <= 1'b1;
            state <= ST_WAIT;
          end
        end
        ST_IDLE, ST_WAIT: begin
          sdaOeN <= 1'b1;
        end
        default: begin
          state <= ST_IDLE;
          sdaOeN <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Stored settings and tap decode
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (storeWrite) begin
      storedSetting[storeAddr] <= storeData;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      tapSelect0 <= {256{1'b0}};
      tapSelect1 <= {256{1'b0}};
    end else begin
      tapSelect0 <= tapDecode(wiperPosition0);
      tapSelect1 <= tapDecode(wiperPosition1);
    end
  end

endmodule // dwss_setting_store

// [tb/dwss_host_model.sv]
// Purpose: Bus host that clocks frames into the setting store
// Assumes: Data wire has a pull-up; host paced by core_clk
// Notes: Serial clock stands high between frames
`timescale 1ns/1ps
module dwss_host_model (
  input wire core_clk,
  input wire sdaPin,
  output logic sclLine = 1'b1,
  output logic sdaPullLow = 1'b0
);
  // One quarter of a 160 ns serial clock period
  task automatic step(input logic s, input logic d);
    sclLine = s;
    sdaPullLow = d;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic bitx(input logic b, output logic r);
    step(1'b0, ~b);
    step(1'b1, ~b);
    r = sdaPin;
    step(1'b1, ~b);
    step(1'b0, ~b);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  // Host releases the ack bit of every byte, so a read ends unacknowledged
  task automatic frame(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d,
                       output logic [7:0] rx, output logic [2:0] acks);
    logic [7:0] unused;
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    xfer(a, unused, acks[2]);
    xfer(c, unused, acks[1]);
    xfer(d, rx, acks[0]);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
endmodule // dwss_host_model

// [tb/dwss_setting_store_asserts.sv]
// Purpose: Port checks for the setting store
// Assumes: Taps registered one cycle behind wipers
// Notes: Bound to every store instance
`timescale 1ns/1ps
module dwss_setting_store_asserts (
  input wire core_clk,
  input wire rst,
  input wire sclPin,
  input wire sdaPin,
  input wire sdaOut,
  input wire sdaOeN,
  input wire [3:0] busSelectStrap,
  input wire writeGuardN,
  input wire [7:0] wiperPosition0,
  input wire [7:0] wiperPosition1,
  input wire [255:0] tapSelect0,
  input wire [255:0] tapSelect1,
  input wire recallBusy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence recallSeq;
    recallBusy ##1 !recallBusy;
  endsequence
  a_recall_pulse: assert property ($fell(rst) |-> recallSeq)
    else $error("recall pulse wrong");
  a_busy_clear: assert property (!$past(rst) |-> !recallBusy)
    else $error("busy outside reset");
  a_tap_follow: assert property (!$past(rst) |->
    tapSelect0 == 256'h1 << $past(wiperPosition0)) else $error("tap0 wrong");
  a_tap_onehot: assert property (!$past(rst) |->
    $onehot(tapSelect1) && tapSelect1[$past(wiperPosition1)]) else $error("tap1 wrong");
  a_sda_pull: assert property (sdaOut == 1'b0)
    else $error("data driven high");
  a_drive_phase: assert property ($changed(sdaOeN) |-> !$past(sclPin))
    else $error("data moved with clock high");
  a_drive_held: assert property ($fell(sdaOeN) |-> !sdaOeN [*8])
    else $error("data pull too short");
  a_wiper_cause: assert property (($changed(wiperPosition0) ||
    $changed(wiperPosition1)) && !$past(recallBusy) |-> $past(sclPin))
    else $error("wiper moved off clock");
endmodule // dwss_setting_store_asserts
bind dwss_setting_store dwss_setting_store_asserts chk (.core_clk(core_clk), .rst(rst),
  .sclPin(sclPin), .sdaPin(sdaPin), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
  .busSelectStrap(busSelectStrap), .writeGuardN(writeGuardN),
  .wiperPosition0(wiperPosition0), .wiperPosition1(wiperPosition1),
  .tapSelect0(tapSelect0), .tapSelect1(tapSelect1), .recallBusy(recallBusy));

// [tb/test_dual_wiper_setting_store.sv]
// Purpose: Self-checking bench for the setting store
// Assumes: Host model paces the serial clock from core_clk
// Notes: Stored cells survive rst, so a second reset shows recall
`timescale 1ns/1ps
`include "dwss_map.vh"
module test_dual_wiper_setting_store;
  logic core_clk, rst, writeGuardN, sdaOut, sdaOeN, recallBusy, sclLine, sdaPullLow;
  logic [3:0] busSelectStrap;
  logic [7:0] wiperPosition0, wiperPosition1, rx, devAddr;
  logic [255:0] tapSelect0, tapSelect1;
  logic [2:0] acks;
  int errCount = 0;
  int nTests = 0;
  // Pull-up: a released wire reads high
  wire sdaPin = ~sdaPullLow & (sdaOeN | sdaOut);
  dwss_setting_store dut (.core_clk(core_clk), .rst(rst), .sclPin(sclLine), .sdaPin(sdaPin),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .busSelectStrap(busSelectStrap),
    .writeGuardN(writeGuardN), .wiperPosition0(wiperPosition0),
    .wiperPosition1(wiperPosition1), .tapSelect0(tapSelect0), .tapSelect1(tapSelect1),
    .recallBusy(recallBusy));
  dwss_host_model host (.core_clk(core_clk), .sdaPin(sdaPin), .sclLine(sclLine),
    .sdaPullLow(sdaPullLow));
  task automatic chk(input string name, input logic [255:0] exp, input logic [255:0] got);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic [2:0] a);
    host.frame(devAddr, c, d, rx, acks);
    chk("acks", a, acks);
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] d);
    host.frame(devAddr, c, 8'hff, rx, acks);
    chk("read", {3'b110, d}, {acks, rx});
  endtask
  task automatic results();
    if (errCount == 0 && nTests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // About 40 frames of 4.5 us each, doubled
  initial begin
    #400000;
    errCount++;
    results();
  end
  initial begin
    rst = 1'b1;
    writeGuardN = 1'b1;
    busSelectStrap = 4'ha;
    devAddr = {`DWSS_FAMILY_ID, 4'ha};
    repeat (4) @(negedge core_clk);
    chk("busy", 1'b1, recallBusy);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    chk("wiper0", `DWSS_STORE_INIT, wiperPosition0);
    chk("wiper1", `DWSS_STORE_INIT, wiperPosition1);
    wr(8'h00, 8'h3c, 3'b111);
    wr(8'h10, 8'hff, 3'b111);
    chk("tap0", 256'h1 << 8'h3c, tapSelect0);
    chk("tap1", 256'h1 << 8'hff, tapSelect1);
    rd(8'h90, 8'hff);
    // All writes land before any read, so aliasing cells would show
    for (int i = 0; i < 8; i++) begin
      wr({3'b010, i[2], 2'b00, i[1:0]}, 8'h1f + 8'h21 * i[7:0], 3'b111);
    end
    chk("wiper0", 8'h3c, wiperPosition0);
    for (int i = 0; i < 8; i++) begin
      rd({3'b110, i[2], 2'b00, i[1:0]}, 8'h1f + 8'h21 * i[7:0]);
    end
    writeGuardN = 1'b0;
    wr(8'h40, 8'h66, 3'b110);
    wr(8'h00, 8'h99, 3'b111);
    rd(8'hc0, 8'h1f);
    chk("wiper0", 8'h99, wiperPosition0);
    rd(8'h80, 8'h99);
    writeGuardN = 1'b1;
    devAddr = {`DWSS_FAMILY_ID, 4'h3};
    wr(8'h00, 8'h44, 3'b000);
    chk("wiper0", 8'h99, wiperPosition0);
    for (int s = 0; s < 16; s++) begin
      busSelectStrap = s[3:0];
      devAddr = {`DWSS_FAMILY_ID, s[3:0]};
      wr(8'h10, 8'h11 * s[7:0], 3'b111);
      chk("wiper1", 8'h11 * s[7:0], wiperPosition1);
    end
    rst = 1'b1;
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    chk("wiper0", 8'h1f, wiperPosition0);
    chk("wiper1", 8'ha3, wiperPosition1);
    chk("tap0", 256'h1 << 8'h1f, tapSelect0);
    chk("busy", 1'b0, recallBusy);
    results();
  end
endmodule // test_dual_wiper_setting_store
